/* hw/acwzd_pkg.sv */
// constants, types and decode functions for the setup-word decoder
`default_nettype none
package acwzd_pkg;
  // ==========================================================
  // setup word layout
  localparam int unsigned CFG_W     = 10;
  localparam logic [9:0]  CFG_RESET = 10'h020;
  localparam int unsigned BIT_REF   = 0;
  localparam int unsigned BIT_MODE  = 1;
  localparam int unsigned BIT_SLEEP = 2;
  localparam int unsigned ARR_LSB   = 3;
  localparam int unsigned ARR_MSB   = 7;
  localparam int unsigned TEST_LO   = 8;
  localparam int unsigned TEST_HI   = 9;
  localparam int unsigned W1_RESET  = 0;
  // ==========================================================
  // register select codes, {hi, lo}
  localparam logic [1:0] SEL_WORD0 = 2'h0;
  localparam logic [1:0] SEL_WORD1 = 2'h1;
  // ==========================================================
  // channel arrangements
  localparam logic [4:0] ARR_POS  = 5'h00;
  localparam logic [4:0] ARR_NEG  = 5'h01;
  localparam logic [4:0] ARR_DIFF = 5'h04;
  localparam logic [4:0] ARR_SCAN = 5'h11;
  localparam logic [1:0] CH_POS   = 2'h0;
  localparam logic [1:0] CH_NEG   = 2'h1;
  localparam logic [1:0] CH_DIFF  = 2'h2;
  localparam logic [1:0] MASK_NONE = 2'h0;
  localparam logic [1:0] MASK_POS  = 2'h1;
  localparam logic [1:0] MASK_NEG  = 2'h2;
  localparam logic [1:0] MASK_BOTH = 2'h3;
  // ==========================================================
  // block counting
  localparam logic [4:0] BLOCK_MIN  = 5'h01;
  localparam logic [4:0] BLOCK_STEP = 5'h01;
  localparam logic [4:0] CNT_ZERO   = 5'h00;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND} acwzd_seq_e;

  function automatic logic word_hit(input logic hi, input logic lo, input logic [1:0] sel);
    word_hit = ({hi, lo} == sel);
  endfunction : word_hit

  function automatic logic arr_legal(input logic [4:0] arr);
    arr_legal = (arr == ARR_POS) || (arr == ARR_NEG) || (arr == ARR_DIFF) || (arr == ARR_SCAN);
  endfunction : arr_legal

  function automatic logic [1:0] arr_mask(input logic [4:0] arr);
    case (arr)
      ARR_POS:  arr_mask = MASK_POS;
      ARR_NEG:  arr_mask = MASK_NEG;
      ARR_DIFF: arr_mask = MASK_BOTH;
      ARR_SCAN: arr_mask = MASK_BOTH;
      default:  arr_mask = MASK_NONE;
    endcase
  endfunction : arr_mask
endpackage : acwzd_pkg
`default_nettype wire

/* hw/acwzd_link_if.sv */
// carrier between the setup decoder and its conversion sequencer
`default_nettype none
interface acwzd_link_if;
  logic       single;
  logic       sleep;
  logic       scan;
  logic       fire;
  logic [1:0] fixed_ch;
  logic [1:0] fixed_mask;
  logic       conv_write;
  logic [1:0] conv_channel;
  logic       sample_hold;
  logic [1:0] hold_mask;
  logic       idle;

  modport ctl (output single, sleep, scan, fire, fixed_ch, fixed_mask,
               input  conv_write, conv_channel, sample_hold, hold_mask, idle);
  modport seq (input  single, sleep, scan, fire, fixed_ch, fixed_mask,
               output conv_write, conv_channel, sample_hold, hold_mask, idle);
endinterface : acwzd_link_if
`default_nettype wire

/* hw/acwzd_seq.sv */
// conversion sequencer: hold pulse and per-channel write strobes
`default_nettype none
module acwzd_seq (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  acwzd_link_if.seq lnk
);
  // ==========================================================
  // state
  acwzd_pkg::acwzd_seq_e state_reg;
  acwzd_pkg::acwzd_seq_e state_next;
  logic       phase_reg;
  logic       phase_next;
  logic       wr_reg;
  logic       wr_next;
  logic [1:0] ch_reg;
  logic [1:0] ch_next;
  logic       hold_reg;
  logic       hold_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  wire  logic [1:0] scan_ch = phase_reg ? acwzd_pkg::CH_NEG : acwzd_pkg::CH_POS;

  // ==========================================================
  // next state; edges that land mid-sequence are dropped
  always_comb
  begin
    state_next = state_reg;
    phase_next = lnk.scan ? phase_reg : 1'b0;
    wr_next    = 1'b0;
    ch_next    = ch_reg;
    hold_next  = 1'b0;
    mask_next  = mask_reg;
    if (lnk.sleep)
    begin
      state_next = acwzd_pkg::SEQ_IDLE;
    end
    else
    begin
      unique case (state_reg)
        acwzd_pkg::SEQ_IDLE:
          if (lnk.fire)
          begin
            hold_next = 1'b1;
            mask_next = lnk.fixed_mask;
            if (lnk.single)
            begin
              state_next = acwzd_pkg::SEQ_FIRST;
            end
            else
            begin
              wr_next    = 1'b1;
              ch_next    = lnk.scan ? scan_ch : lnk.fixed_ch;
              phase_next = lnk.scan & ~phase_reg;
            end
          end
        acwzd_pkg::SEQ_FIRST:
        begin
          wr_next    = 1'b1;
          ch_next    = lnk.scan ? acwzd_pkg::CH_POS : lnk.fixed_ch;
          state_next = lnk.scan ? acwzd_pkg::SEQ_SECOND : acwzd_pkg::SEQ_IDLE;
        end
        acwzd_pkg::SEQ_SECOND:
        begin
          wr_next    = 1'b1;
          ch_next    = acwzd_pkg::CH_NEG;
          state_next = acwzd_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= acwzd_pkg::SEQ_IDLE;
      phase_reg <= 1'b0;
      wr_reg    <= 1'b0;
      ch_reg    <= acwzd_pkg::CH_DIFF;
      hold_reg  <= 1'b0;
      mask_reg  <= acwzd_pkg::MASK_NONE;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      wr_reg    <= wr_next;
      ch_reg    <= ch_next;
      hold_reg  <= hold_next;
      mask_reg  <= mask_next;
    end
  end

  assign lnk.conv_write   = wr_reg;
  assign lnk.conv_channel = ch_reg;
  assign lnk.sample_hold  = hold_reg;
  assign lnk.hold_mask    = mask_reg;
  assign lnk.idle         = (state_reg == acwzd_pkg::SEQ_IDLE);

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !clk_en);

  sequence single_go;
    lnk.fire && lnk.single && (state_reg == acwzd_pkg::SEQ_IDLE);
  endsequence
  sequence pos_then_neg;
    lnk.conv_write && (lnk.conv_channel == acwzd_pkg::CH_POS)
    ##1 lnk.conv_write && (lnk.conv_channel == acwzd_pkg::CH_NEG);
  endsequence

  scan_order_a: assert property (single_go and lnk.scan |=> lnk.sample_hold ##1 pos_then_neg)
    else $error("single scan did not write pos then neg");
  single_one_a: assert property (single_go and !lnk.scan |=>
    (lnk.sample_hold && !lnk.conv_write) ##1 lnk.conv_write ##1 !lnk.conv_write)
    else $error("single conversion sequence wrong");
  cont_write_a: assert property (lnk.fire && !lnk.single && lnk.idle |=>
    lnk.conv_write && lnk.sample_hold)
    else $error("continuous edge gave no write");
  sleep_quiet_a: assert property (lnk.sleep |=> !lnk.conv_write && !lnk.sample_hold)
    else $error("activity while asleep");
endmodule : acwzd_seq
`default_nettype wire

/* hw/acwzd_top.sv */
// setup-word decoder: latch, decode and conversion pacing
//
// Contract
// - bit 0 picks internal or external reference
// - continuous: one write per pace falling edge
// - single mode: pace pin is start strobe
// - start edge holds all selected inputs together
// - single mode: ready once block count reached
// - sleep stops converting, bus stays usable
// - arrangement 00000 positive, 00001 negative input
// - arrangement 00100 positive minus negative differential
// - 10001 scans positive then negative, repeating
// - reset value has only bit 5 set
// - bits 9:8 select normal or reference input
// - three check voltages offered as inputs
// - word latched with both selects low
// - setup word cannot be read back
// - device reset bit restores setup word
`default_nettype none
module acwzd_top (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       bus_write,
  input  wire logic       reg_select_lo,
  input  wire logic       reg_select_hi,
  input  wire logic [9:0] bus_data,
  input  wire logic [4:0] block_size,
  input  wire logic       conversion_pace_pin,
  output logic            use_ext_ref,
  output logic            core_sleep,
  output logic            check_voltage_sel_lo,
  output logic            check_voltage_sel_hi,
  output logic            conv_write,
  output logic [1:0]      conv_channel,
  output logic            sample_hold,
  output logic [1:0]      hold_mask,
  output logic            block_ready_out
);
  // ==========================================================
  // bus decode; no read path exists for the setup word
  logic [acwzd_pkg::CFG_W-1:0] cfg_reg;
  logic [acwzd_pkg::CFG_W-1:0] cfg_next;
  wire  logic hit0 = bus_write &&
                     acwzd_pkg::word_hit(reg_select_hi, reg_select_lo, acwzd_pkg::SEL_WORD0);
  wire  logic hit1 = bus_write &&
                     acwzd_pkg::word_hit(reg_select_hi, reg_select_lo, acwzd_pkg::SEL_WORD1);
  wire  logic dev_reset = hit1 && bus_data[acwzd_pkg::W1_RESET];

  // the device reset of the second word wins; both cannot hit at once anyway
  assign cfg_next = dev_reset ? acwzd_pkg::CFG_RESET :
                    hit0      ? bus_data :
                                cfg_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_reg <= acwzd_pkg::CFG_RESET;
    end
    else if (clk_en)
    begin
      cfg_reg <= cfg_next;
    end
  end

  // ==========================================================
  // field decode
  wire logic [4:0] arrangement = cfg_reg[acwzd_pkg::ARR_MSB:acwzd_pkg::ARR_LSB];
  wire logic input_pick_lo   = arrangement[0];
  wire logic paired_input_lo = arrangement[2];
  wire logic paired_input_hi = arrangement[3];
  wire logic input_pick_hi   = arrangement[1];
  wire logic scan_on         = arrangement[4];
  // reserved codes are undefined; here they simply never convert
  wire logic arr_ok = acwzd_pkg::arr_legal(arrangement);
  wire logic single_mode = cfg_reg[acwzd_pkg::BIT_MODE];
  wire logic sleeping    = cfg_reg[acwzd_pkg::BIT_SLEEP];
  logic [1:0] fixed_ch;

  always_comb
  begin
    fixed_ch = acwzd_pkg::CH_POS;
    if (paired_input_lo && !paired_input_hi && !input_pick_hi && !input_pick_lo)
    begin
      fixed_ch = acwzd_pkg::CH_DIFF;
    end
    else if (input_pick_lo && !scan_on)
    begin
      fixed_ch = acwzd_pkg::CH_NEG;
    end
  end

  // ==========================================================
  // pace pin: clock in continuous mode, start strobe in single mode
  logic pace_reg;
  wire  logic conversion_start_strobe = conversion_pace_pin;
  wire  logic pace_fall = pace_reg && !conversion_start_strobe;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pace_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      pace_reg <= conversion_pace_pin;
    end
  end

  acwzd_link_if lnk ();

  assign lnk.single     = single_mode;
  assign lnk.sleep      = sleeping;
  assign lnk.scan       = scan_on && arr_ok;
  assign lnk.fire       = pace_fall && !sleeping && arr_ok;
  assign lnk.fixed_ch   = fixed_ch;
  assign lnk.fixed_mask = acwzd_pkg::arr_mask(arrangement);

  acwzd_seq u_seq (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .lnk    (lnk)
  );

  // ==========================================================
  // block counting; a block size of zero counts as one
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic       ready_reg;
  wire  logic [4:0] blk     = (block_size == acwzd_pkg::CNT_ZERO) ? acwzd_pkg::BLOCK_MIN
                                                                  : block_size;
  wire  logic [4:0] cnt_inc = cnt_reg + acwzd_pkg::BLOCK_STEP;
  wire  logic       blk_done = lnk.conv_write && (cnt_inc >= blk);

  assign cnt_next = dev_reset      ? acwzd_pkg::CNT_ZERO :
                    blk_done       ? acwzd_pkg::CNT_ZERO :
                    lnk.conv_write ? cnt_inc : cnt_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_reg   <= acwzd_pkg::CNT_ZERO;
      ready_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_reg   <= cnt_next;
      ready_reg <= blk_done && !dev_reset;
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign use_ext_ref          = cfg_reg[acwzd_pkg::BIT_REF];
  assign core_sleep           = cfg_reg[acwzd_pkg::BIT_SLEEP];
  // a nonzero pair swaps the analog input for a check voltage
  assign check_voltage_sel_lo = cfg_reg[acwzd_pkg::TEST_LO];
  assign check_voltage_sel_hi = cfg_reg[acwzd_pkg::TEST_HI];
  assign conv_write           = lnk.conv_write;
  assign conv_channel         = lnk.conv_channel;
  assign sample_hold          = lnk.sample_hold;
  assign hold_mask            = lnk.hold_mask;
  assign block_ready_out      = ready_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !clk_en);

  word_load_a: assert property (hit0 && !dev_reset |=>
    {check_voltage_sel_hi, check_voltage_sel_lo, use_ext_ref} ==
    {$past(bus_data[acwzd_pkg::TEST_HI]), $past(bus_data[acwzd_pkg::TEST_LO]),
     $past(bus_data[acwzd_pkg::BIT_REF])})
    else $error("setup word not latched");
  ref_pick_a: assert property (hit0 |=> use_ext_ref == $past(bus_data[0]))
    else $error("reference select wrong");
  dev_reset_a: assert property (dev_reset |=> cfg_reg == acwzd_pkg::CFG_RESET
    && !block_ready_out)
    else $error("device reset did not restore word");
  reset_val_a: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_n |=> cfg_reg == acwzd_pkg::CFG_RESET && !conv_write && !block_ready_out)
    else $error("reset value wrong");
  ready_cause_a: assert property ($rose(block_ready_out) |-> $past(conv_write))
    else $error("ready without a conversion");
  ready_one_a: assert property (block_size == acwzd_pkg::BLOCK_MIN && conv_write
    && !dev_reset |=> block_ready_out)
    else $error("block of one gave no ready");
  neg_chan_a: assert property (lnk.fire && !single_mode && lnk.idle
    && arrangement == acwzd_pkg::ARR_NEG |=> conv_channel == acwzd_pkg::CH_NEG)
    else $error("negative input not selected");
  diff_chan_a: assert property (lnk.fire && !single_mode && lnk.idle
    && arrangement == acwzd_pkg::ARR_DIFF |=> conv_channel == acwzd_pkg::CH_DIFF
    && hold_mask == acwzd_pkg::MASK_BOTH)
    else $error("differential channel not selected");
  reserved_a: assert property (!arr_ok |=> !sample_hold)
    else $error("reserved arrangement converted");
  // sleep keeps the bus alive; only conversions stop
  sleep_bus_a: assert property (hit0 && sleeping |=>
    cfg_reg == $past(bus_data))
    else $error("write lost while asleep");
  sleep_idle_a: assert property (sleeping |=> lnk.idle && !conv_write)
    else $error("sequence kept running while asleep");
  pos_chan_a: assert property (lnk.fire && !single_mode && lnk.idle
    && arrangement == acwzd_pkg::ARR_POS |=> conv_channel == acwzd_pkg::CH_POS
    && hold_mask == acwzd_pkg::MASK_POS)
    else $error("positive input not selected");
  scan_mask_a: assert property (lnk.fire && lnk.idle && lnk.scan |=>
    sample_hold && hold_mask == acwzd_pkg::MASK_BOTH)
    else $error("scan did not hold both inputs");
  hold_cause_a: assert property ($rose(sample_hold) |-> $past(lnk.fire))
    else $error("hold without a start edge");
  test_sel_a: assert property (hit0 |=>
    {check_voltage_sel_hi, check_voltage_sel_lo} ==
    $past(bus_data[acwzd_pkg::TEST_HI:acwzd_pkg::TEST_LO]))
    else $error("check voltage select wrong");
endmodule : acwzd_top
`default_nettype wire

/* tb/acwzd_host.sv */
// host partner model: setup-word writes and pace pin pulses
`default_nettype none
// ==========================================================
// host model
module acwzd_host (
  input  wire logic mclk,
  output logic       bus_write,
  output logic       reg_select_lo,
  output logic       reg_select_hi,
  output logic [9:0] bus_data,
  output logic       conversion_pace_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    bus_write           = 1'b0;
    reg_select_lo       = 1'b0;
    reg_select_hi       = 1'b0;
    bus_data            = 10'h000;
    conversion_pace_pin = 1'b0;
  end

  // one write strobe, select and data held until the taking edge
  task automatic wr(input logic [1:0] sel, input logic [9:0] d);
    @(posedge mclk);
    bus_write                      <= 1'b1;
    {reg_select_hi, reg_select_lo} <= sel;
    bus_data                       <= d;
    @(posedge mclk);
    bus_write <= 1'b0;
    // released bus shows the inverse so a stale value is never read
    bus_data  <= ~d;
  endtask : wr

  // single pace period; a free-running pace clock is not modelled
  task automatic pulse();
    @(posedge mclk);
    conversion_pace_pin <= 1'b1;
    @(posedge mclk);
    conversion_pace_pin <= 1'b0;
  endtask : pulse
endmodule : acwzd_host
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the setup-word decoder
`default_nettype none
// ==========================================================
// bench top
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk;
  logic       rst_n;
  logic       clk_en;
  logic [4:0] block_size;
  logic       bus_write;
  logic       sel_lo;
  logic       sel_hi;
  logic [9:0] bus_data;
  logic       pin;
  logic       ext_ref;
  logic       sleep;
  logic       tst_lo;
  logic       tst_hi;
  logic       conv_write;
  logic [1:0] conv_channel;
  logic       sample_hold;
  logic [1:0] hold_mask;
  logic       ready;
  int         error_cnt;
  int         n_checks;
  int         nw;
  int         w_at [4];
  int         hold_at;
  int         ready_at;
  logic [1:0] ch [4];
  logic [1:0] mask;

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  acwzd_host host (
    .mclk                (mclk),
    .bus_write           (bus_write),
    .reg_select_lo       (sel_lo),
    .reg_select_hi       (sel_hi),
    .bus_data            (bus_data),
    .conversion_pace_pin (pin)
  );

  acwzd_top DUT (
    .mclk                 (mclk),
    .rst_n                (rst_n),
    .clk_en               (clk_en),
    .bus_write            (bus_write),
    .reg_select_lo        (sel_lo),
    .reg_select_hi        (sel_hi),
    .bus_data             (bus_data),
    .block_size           (block_size),
    .conversion_pace_pin  (pin),
    .use_ext_ref          (ext_ref),
    .core_sleep           (sleep),
    .check_voltage_sel_lo (tst_lo),
    .check_voltage_sel_hi (tst_hi),
    .conv_write           (conv_write),
    .conv_channel         (conv_channel),
    .sample_hold          (sample_hold),
    .hold_mask            (hold_mask),
    .block_ready_out      (ready)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // fixed window after a pace fall; records writes, hold and ready
  task automatic obs();
    nw       = 0;
    hold_at  = -1;
    ready_at = -1;
    mask     = 2'h0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1;
      if (conv_write === 1'b1 && nw < 4)
      begin
        ch[nw]   = conv_channel;
        w_at[nw] = i;
        nw++;
      end
      if (sample_hold === 1'b1)
      begin
        hold_at = i;
        mask    = hold_mask;
      end
      if (ready === 1'b1)
        ready_at = i;
    end
  endtask : obs

  task automatic cfg(input logic [3:0] exp);
    #1;
    chk(10'({tst_hi, tst_lo, sleep, ext_ref}), 10'(exp));
  endtask : cfg

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // main sequence
  initial
  begin
    error_cnt  = 0;
    n_checks   = 0;
    rst_n      = 1'b0;
    clk_en     = 1'b1;
    block_size = 5'h01;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    cfg(4'h0);
    // reset arrangement is differential, continuous pacing
    host.pulse();
    obs();
    chk(10'(nw), 10'h001);
    chk(10'(ch[0]), 10'h002);
    chk(10'(mask), 10'h003);
    chk(10'(hold_at), 10'(w_at[0]));
    chk(10'(ready_at), 10'(w_at[0] + 1));
    // every test-input code, both references
    for (int t = 0; t < 4; t++)
    begin
      host.wr(2'h0, {2'(t), 7'h04, 1'(t)});
      cfg({2'(t), 1'b0, 1'(t)});
    end
    // reserved selects leave the word alone
    host.wr(2'h2, 10'h3ff);
    host.wr(2'h3, 10'h3ff);
    cfg(4'hd);
    // single-ended continuous arrangements
    for (int a = 0; a < 2; a++)
    begin
      host.wr(2'h0, {6'h00, 1'(a), 3'h0});
      host.pulse();
      obs();
      chk(10'(nw), 10'h001);
      chk(10'(ch[0]), 10'(a));
      chk(10'(mask), 10'(a + 1));
    end
    // sleep drops conversions but bus writes still land
    host.wr(2'h0, 10'h024);
    cfg(4'h2);
    host.pulse();
    obs();
    chk(10'(nw), 10'h000);
    host.wr(2'h0, 10'h325);
    cfg(4'hf);
    // device reset bit of the second word restores the setup word
    host.wr(2'h1, 10'h001);
    cfg(4'h0);
    host.pulse();
    obs();
    chk(10'(ch[0]), 10'h002);
    // single-shot scan, block of two
    host.wr(2'h0, 10'h08a);
    block_size <= 5'h02;
    host.pulse();
    obs();
    chk(10'(nw), 10'h002);
    chk(10'(mask), 10'h003);
    chk(10'(ch[0]), 10'h000);
    chk(10'(ch[1]), 10'h001);
    chk(10'(w_at[0]), 10'(hold_at + 1));
    chk(10'(w_at[1]), 10'(hold_at + 2));
    chk(10'(ready_at), 10'(hold_at + 3));
    // a second strobe repeats the scan from the positive input
    host.pulse();
    obs();
    chk(10'(nw), 10'h002);
    chk(10'(ch[0]), 10'h000);
    // continuous scan alternates positive and negative across edges
    host.wr(2'h0, 10'h088);
    for (int k = 0; k < 3; k++)
    begin
      host.pulse();
      obs();
      chk(10'(nw), 10'h001);
      chk(10'(ch[0]), 10'(k % 2));
      chk(10'(mask), 10'h003);
    end
    // single-shot fixed channel: hold, then one write a cycle later
    host.wr(2'h0, 10'h022);
    host.pulse();
    obs();
    chk(10'(nw), 10'h001);
    chk(10'(ch[0]), 10'h002);
    chk(10'(w_at[0]), 10'(hold_at + 1));
    // reserved code: by choice nothing is sampled or written
    host.wr(2'h0, 10'h010);
    host.pulse();
    obs();
    chk(10'(nw), 10'h000);
    chk(10'(hold_at + 1), 10'h000);
    // clock enable low: a write is not taken
    @(posedge mclk);
    clk_en <= 1'b0;
    host.wr(2'h0, 10'h001);
    clk_en <= 1'b1;
    cfg(4'h0);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
